// ### rtl/step_seq_map.vh
// Register map, field codes and timing constants of the data-set step sequencer
`ifndef STEP_SEQ_MAP_VH
`define STEP_SEQ_MAP_VH

// Register byte offsets
`define OFS_CONTROL_MODE 8'h00
`define OFS_STEP_CONFIG 8'h04
`define OFS_VALUE_ONE 8'h08
`define OFS_VALUE_TWO 8'h0C
`define OFS_STARTUP_MANNER 8'h10
`define OFS_SEQ_SETUP 8'h14
`define OFS_TABLE_INDEX 8'h18
`define OFS_TABLE_POS 8'h1C
`define OFS_TABLE_COMMIT 8'h20
`define OFS_STATUS 8'h24

// Reset values
`define RST_CONTROL_MODE 16'h0000
`define RST_STEP_CONFIG 16'h0000
`define RST_VALUE_ONE 16'h0000
`define RST_VALUE_TWO 16'h0000
`define RST_STARTUP_MANNER 16'h0000

// Digit codes
`define MODE_SEQUENCE 4'hC
`define MANNER_SINGLE 4'h0
`define COND_NONE 4'h0
`define COND_DELAY 4'h1
`define COND_EDGE 4'h2
`define COND_LEVEL 4'h3
`define CONJ_NONE 4'h0
`define CONJ_AND 4'h1
`define CONJ_OR 4'h2
`define STYLE_ABORT 4'h0
`define STYLE_STANDARD 4'h1

// Condition values
`define VAL_RISE 16'h0000
`define VAL_FALL 16'h0001
`define VAL_ANY_EDGE 16'h0002
`define VAL_HIGH 16'h0003
`define VAL_LOW 16'h0004

// Data set types
`define SET_INVALID 2'h0
`define SET_ABSOLUTE 2'h1
`define SET_RELATIVE 2'h2

// Highest set index per definition manner (7 by parameter, 31 by communication)
`define LAST_SET_PARAM 5'h07
`define LAST_SET_COMM 5'h1F

// Timing
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/data_set_mem.v
// Data set table: type and target of each of up to 32 sets, registered read
`timescale 1ns/1ps
`default_nettype none
module data_set_mem (
	// Clock
	input wire core_clk,
	// Write port
	input wire we,
	input wire [4:0] waddr,
	input wire [33:0] wdata,
	// Read port
	input wire [4:0] raddr,
	output reg [33:0] rdata_q
);
	reg [33:0] mem [0:31];

	always @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule // data_set_mem
`default_nettype wire

// ### rtl/step_condition_eval.v
// One step-change condition: none, millisecond delay, edge or level
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_map.vh"
module step_condition_eval (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Control
	input wire arm,
	input wire ms_tick,
	input wire [3:0] ctype,
	input wire [15:0] cval,
	// Step input, synchronised
	input wire step_level,
	input wire step_rise,
	input wire step_fall,
	// Result
	output reg met,
	output reg bad
);
	reg [15:0] ms_q;
	reg rise_seen_q;
	reg fall_seen_q;

	// Edges seen since the last arm; an edge in the arm cycle is kept
	always @(posedge core_clk) begin
		if (rst) begin
			ms_q <= 16'h0000;
			rise_seen_q <= 1'b0;
			fall_seen_q <= 1'b0;
		end else begin
			if (arm) begin
				ms_q <= 16'h0000;
			end else if (ms_tick && ms_q != 16'hFFFF) begin
				ms_q <= ms_q + 16'h0001; // R6
			end
			rise_seen_q <= step_rise | (rise_seen_q & ~arm);
			fall_seen_q <= step_fall | (fall_seen_q & ~arm);
		end
	end

	always @* begin
		met = 1'b0;
		bad = 1'b0;
		case (ctype)
			`COND_NONE: met = 1'b1; // R10
			`COND_DELAY: met = (ms_q >= cval); // R6 R11
			`COND_EDGE: begin
				if (cval == `VAL_RISE) begin // R7
					met = rise_seen_q;
				end else if (cval == `VAL_FALL) begin
					met = fall_seen_q;
				end else if (cval == `VAL_ANY_EDGE) begin
					met = rise_seen_q | fall_seen_q;
				end else begin
					bad = 1'b1;
				end
			end
			`COND_LEVEL: begin
				if (cval == `VAL_HIGH) begin // R8
					met = step_level;
				end else if (cval == `VAL_LOW) begin
					met = ~step_level;
				end else begin
					bad = 1'b1;
				end
			end
			default: bad = 1'b1;
		endcase
	end
endmodule // step_condition_eval
`default_nettype wire

// ### rtl/step_sequencer_top.v
// Data-set sequence engine with AXI4-Lite registers and step-change conditions
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_map.vh"
// Function
// R1: Up to 8 or 32 data sets
// R2: Each set moves absolute or relative
// R3: Active only in sequence control mode
// R4: Lowest manner digit 0 selects single manner
// R5: Condition type 0 steps at once
// R6: Type 1 waits value-one milliseconds
// R7: Edge values: rise, fall, either, invalid
// R8: Level values: high, low, invalid
// R9: Second type: none, edge or level; the code also accepts type 1 as a millisecond delay on value two
// R10: Value one ignored when type none
// R11: Value two decoded like value one
// R12: Conjunction digit: none, AND, OR
// R13: Start input enables motion, drop stops
// R14: Standard waits in-position; aborting interrupts
// R15: Controller supplies the step input
// R16: Synchronise step input; delay from in-position; aborting style counts the delay from the move start instead
module step_sequencer_top #(
	parameter MS_CYCLES = `MS_CYCLES
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// AXI4-Lite write address
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [7:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [7:0] s_axi_araddr,
	// AXI4-Lite read data
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	// Controller pins
	input wire start_pin,
	input wire step_pin,
	// Motion core
	input wire move_in_position,
	output reg move_start_q,
	output reg move_abort_q,
	output reg move_absolute_q,
	output reg [31:0] move_target_q,
	output reg [4:0] move_set_q,
	output reg motion_enable_q
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_FETCH = 3'h1;
	localparam [2:0] S_ISSUE = 3'h2;
	localparam [2:0] S_MOVE = 3'h3;
	localparam [2:0] S_WAIT = 3'h4;
	localparam [31:0] MS_LAST_FULL = MS_CYCLES - 1;
	// Millisecond divider is 17 bits wide, so the terminal count is cut to fit
	localparam [16:0] MS_LAST = MS_LAST_FULL[16:0];

	function [31:0] merge_strb;
		input [31:0] old;
		input [31:0] new_data;
		input [3:0] strb;
		integer i;
		begin
			merge_strb = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge_strb[i*8 +: 8] = new_data[i*8 +: 8];
				end
			end
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_CONTROL_MODE) || (a == `OFS_STEP_CONFIG) ||
				(a == `OFS_VALUE_ONE) || (a == `OFS_VALUE_TWO) ||
				(a == `OFS_STARTUP_MANNER) || (a == `OFS_SEQ_SETUP) ||
				(a == `OFS_TABLE_INDEX) || (a == `OFS_TABLE_POS) ||
				(a == `OFS_TABLE_COMMIT) || (a == `OFS_STATUS);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [15:0] control_mode_select_q;
	reg [15:0] step_condition_config_q;
	reg [15:0] step_condition_value_one_q;
	reg [15:0] step_condition_value_two_q;
	reg [15:0] set_startup_manner_q;
	reg comm_manner_q;
	reg [4:0] last_set_q;
	reg [4:0] table_index_q;
	reg [31:0] table_pos_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [7:0] ar_addr_q;
	reg [31:0] old_word;
	reg [31:0] read_word;
	wire [31:0] merged = merge_strb(old_word, w_data_q, w_strb_q);
	wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire table_we = do_write && aw_addr_q == `OFS_TABLE_COMMIT && w_strb_q[0];

	reg [2:0] state_q;
	reg [4:0] set_q;
	reg cond_bad_q;
	reg done_q;
	wire seq_mode = control_mode_select_q[7:4] == `MODE_SEQUENCE; // R3

	always @* begin
		old_word = 32'h0000_0000;
		if (aw_addr_q == `OFS_CONTROL_MODE) begin
			old_word = {16'h0000, control_mode_select_q};
		end else if (aw_addr_q == `OFS_STEP_CONFIG) begin
			old_word = {16'h0000, step_condition_config_q};
		end else if (aw_addr_q == `OFS_VALUE_ONE) begin
			old_word = {16'h0000, step_condition_value_one_q};
		end else if (aw_addr_q == `OFS_VALUE_TWO) begin
			old_word = {16'h0000, step_condition_value_two_q};
		end else if (aw_addr_q == `OFS_STARTUP_MANNER) begin
			old_word = {16'h0000, set_startup_manner_q};
		end else if (aw_addr_q == `OFS_SEQ_SETUP) begin
			old_word = {19'h0_0000, last_set_q, 7'h00, comm_manner_q};
		end else if (aw_addr_q == `OFS_TABLE_INDEX) begin
			old_word = {27'h000_0000, table_index_q};
		end else if (aw_addr_q == `OFS_TABLE_POS) begin
			old_word = table_pos_q;
		end
	end

	always @* begin
		read_word = 32'h0000_0000;
		if (ar_addr_q == `OFS_CONTROL_MODE) begin
			read_word = {16'h0000, control_mode_select_q};
		end else if (ar_addr_q == `OFS_STEP_CONFIG) begin
			read_word = {16'h0000, step_condition_config_q};
		end else if (ar_addr_q == `OFS_VALUE_ONE) begin
			read_word = {16'h0000, step_condition_value_one_q};
		end else if (ar_addr_q == `OFS_VALUE_TWO) begin
			read_word = {16'h0000, step_condition_value_two_q};
		end else if (ar_addr_q == `OFS_STARTUP_MANNER) begin
			read_word = {16'h0000, set_startup_manner_q};
		end else if (ar_addr_q == `OFS_SEQ_SETUP) begin
			read_word = {19'h0_0000, last_set_q, 7'h00, comm_manner_q};
		end else if (ar_addr_q == `OFS_TABLE_INDEX) begin
			read_word = {27'h000_0000, table_index_q};
		end else if (ar_addr_q == `OFS_TABLE_POS) begin
			read_word = table_pos_q;
		end else if (ar_addr_q == `OFS_STATUS) begin
			read_word = {19'h0_0000, set_q, 1'b0, state_q, done_q, cond_bad_q,
				(state_q != S_IDLE), seq_mode};
		end
	end

	// Write address and data taken in either order, answered once both are held
	always @(posedge core_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			control_mode_select_q <= `RST_CONTROL_MODE;
			step_condition_config_q <= `RST_STEP_CONFIG;
			step_condition_value_one_q <= `RST_VALUE_ONE;
			step_condition_value_two_q <= `RST_VALUE_TWO;
			set_startup_manner_q <= `RST_STARTUP_MANNER;
			comm_manner_q <= 1'b0;
			last_set_q <= 5'h00;
			table_index_q <= 5'h00;
			table_pos_q <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr_q) && aw_addr_q != `OFS_STATUS ?
					`RESP_OKAY : `RESP_SLVERR;
				if (aw_addr_q == `OFS_CONTROL_MODE) begin
					control_mode_select_q <= merged[15:0];
				end else if (aw_addr_q == `OFS_STEP_CONFIG) begin
					step_condition_config_q <= merged[15:0];
				end else if (aw_addr_q == `OFS_VALUE_ONE) begin
					step_condition_value_one_q <= merged[15:0];
				end else if (aw_addr_q == `OFS_VALUE_TWO) begin
					step_condition_value_two_q <= merged[15:0];
				end else if (aw_addr_q == `OFS_STARTUP_MANNER) begin
					set_startup_manner_q <= merged[15:0];
				end else if (aw_addr_q == `OFS_SEQ_SETUP) begin
					comm_manner_q <= merged[0];
					last_set_q <= merged[12:8];
				end else if (aw_addr_q == `OFS_TABLE_INDEX) begin
					table_index_q <= merged[4:0];
				end else if (aw_addr_q == `OFS_TABLE_POS) begin
					table_pos_q <= merged;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
			ar_addr_q <= 8'h00;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_addr_q <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end
			if (!s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_word;
				s_axi_rresp <= mapped(ar_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree
	reg [2:0] start_sync_q;
	reg [2:0] step_sync_q;
	reg start_q;
	reg step_q;
	reg start_prev_q;
	reg step_prev_q;

	always @(posedge core_clk) begin
		if (rst) begin
			start_sync_q <= 3'h0;
			step_sync_q <= 3'h0;
			start_q <= 1'b0;
			step_q <= 1'b0;
			start_prev_q <= 1'b0;
			step_prev_q <= 1'b0;
		end else begin
			start_sync_q <= {start_sync_q[1:0], start_pin};
			step_sync_q <= {step_sync_q[1:0], step_pin}; // R15 R16
			if (start_sync_q[1] == start_sync_q[2]) begin
				start_q <= start_sync_q[2];
			end
			if (step_sync_q[1] == step_sync_q[2]) begin
				step_q <= step_sync_q[2]; // R16
			end
			start_prev_q <= start_q;
			step_prev_q <= step_q;
		end
	end

	wire step_rise = step_q & ~step_prev_q;
	wire step_fall = ~step_q & step_prev_q;
	wire start_rise = start_q & ~start_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Millisecond tick, restarted on arm so a delay counts whole milliseconds
	reg arm_q;
	reg [16:0] ms_cnt_q;
	reg ms_tick_q;

	always @(posedge core_clk) begin
		if (rst || arm_q) begin
			ms_cnt_q <= 17'h0_0000;
			ms_tick_q <= 1'b0;
		end else if (ms_cnt_q == MS_LAST) begin
			ms_cnt_q <= 17'h0_0000;
			ms_tick_q <= 1'b1;
		end else begin
			ms_cnt_q <= ms_cnt_q + 17'h0_0001;
			ms_tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conditions
	wire [3:0] type_one = step_condition_config_q[3:0];
	wire [3:0] type_two = step_condition_config_q[7:4];
	wire [3:0] conj = step_condition_config_q[11:8];
	wire standard = step_condition_config_q[15:12] == `STYLE_STANDARD;
	wire met_one;
	wire bad_one;
	wire met_two;
	wire bad_two;

	step_condition_eval cond_one (
		.core_clk(core_clk),
		.rst(rst),
		.arm(arm_q),
		.ms_tick(ms_tick_q),
		.ctype(type_one),
		.cval(step_condition_value_one_q),
		.step_level(step_q),
		.step_rise(step_rise),
		.step_fall(step_fall),
		.met(met_one),
		.bad(bad_one)
	);

	step_condition_eval cond_two (
		.core_clk(core_clk),
		.rst(rst),
		.arm(arm_q),
		.ms_tick(ms_tick_q),
		.ctype(type_two),
		.cval(step_condition_value_two_q),
		.step_level(step_q),
		.step_rise(step_rise),
		.step_fall(step_fall),
		.met(met_two),
		.bad(bad_two)
	);

	reg combined;
	reg cond_bad;

	always @* begin
		combined = 1'b0;
		cond_bad = 1'b0;
		if (type_one == `COND_NONE) begin
			combined = 1'b1; // R5
		end else if (conj == `CONJ_NONE) begin
			combined = met_one; // R12
			cond_bad = bad_one;
		end else if (conj == `CONJ_AND) begin
			combined = met_one & met_two; // R12 R9
			cond_bad = bad_one | bad_two;
		end else if (conj == `CONJ_OR) begin
			combined = met_one | met_two; // R12 R9
			cond_bad = bad_one | bad_two;
		end else begin
			cond_bad = 1'b1;
		end
	end

	// Invalid settings hold the sequence rather than step on garbage
	wire step_ok = combined & ~cond_bad & ~arm_q;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	wire single = set_startup_manner_q[3:0] == `MANNER_SINGLE; // R4
	wire run_ok = seq_mode & single & start_q; // R13
	wire [4:0] last_set = comm_manner_q ? last_set_q :
		(last_set_q > `LAST_SET_PARAM ? `LAST_SET_PARAM : last_set_q); // R1
	wire [33:0] set_word;

	data_set_mem table_mem (
		.core_clk(core_clk),
		.we(table_we),
		.waddr(table_index_q),
		.wdata({w_data_q[1:0], table_pos_q}),
		.raddr(set_q),
		.rdata_q(set_word)
	);

	always @(posedge core_clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			set_q <= 5'h00;
			arm_q <= 1'b0;
			cond_bad_q <= 1'b0;
			done_q <= 1'b0;
			move_start_q <= 1'b0;
			move_abort_q <= 1'b0;
			move_absolute_q <= 1'b0;
			move_target_q <= 32'h0000_0000;
			move_set_q <= 5'h00;
			motion_enable_q <= 1'b0;
		end else begin
			arm_q <= 1'b0;
			move_start_q <= 1'b0;
			move_abort_q <= 1'b0;
			motion_enable_q <= run_ok; // R13
			cond_bad_q <= cond_bad;
			if (!run_ok) begin
				state_q <= S_IDLE; // R13
			end else begin
				case (state_q)
					S_IDLE: begin
						// A fresh OFF to ON edge is needed to rerun
						if (start_rise) begin
							set_q <= 5'h00;
							done_q <= 1'b0;
							state_q <= S_FETCH;
						end
					end
					S_FETCH: state_q <= S_ISSUE;
					S_ISSUE: begin
						if (set_word[33:32] == `SET_INVALID) begin
							done_q <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							move_start_q <= 1'b1;
							move_absolute_q <= set_word[33:32] == `SET_ABSOLUTE; // R2
							move_target_q <= set_word[31:0];
							move_set_q <= set_q;
							arm_q <= ~standard; // R14
							state_q <= S_MOVE;
						end
					end
					S_MOVE: begin
						if (standard) begin
							if (move_in_position) begin
								arm_q <= 1'b1; // R16
								state_q <= S_WAIT;
							end
						end else if (step_ok) begin
							move_abort_q <= ~move_in_position; // R14
							if (set_q == last_set) begin
								done_q <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								set_q <= set_q + 5'h01;
								state_q <= S_FETCH;
							end
						end
					end
					S_WAIT: begin
						if (step_ok) begin // R14
							if (set_q == last_set) begin
								done_q <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								set_q <= set_q + 5'h01;
								state_q <= S_FETCH;
							end
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule // step_sequencer_top
`default_nettype wire

// ### test/step_ctrl_model.sv
// Model of the external controller driving the startup and step pins
`timescale 1ns/1ps
`default_nettype none
module step_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Commands from the bench
	input wire logic start_cmd,
	input wire logic step_cmd,
	// Pins toward the block
	output logic start_pin,
	output logic step_pin
);
	// Pins move just after the edge, like a real output stage
	always @(posedge core_clk) begin
		start_pin <= start_cmd;
		step_pin <= step_cmd;
	end
endmodule // step_ctrl_model
`default_nettype wire

// ### test/step_seq_checks_assertions.sv
// Concurrent checks on the ports of the step sequencer
`timescale 1ns/1ps
`default_nettype none
module step_seq_checks (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pins and motion core
	input wire logic start_pin,
	input wire logic move_start_q,
	input wire logic move_abort_q,
	input wire logic move_absolute_q,
	input wire logic [31:0] move_target_q,
	input wire logic motion_enable_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence wr_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Pin sync takes about five cycles, eight low ones must have stopped motion
	sequence start_off_long;
		!start_pin [*8];
	endsequence
	AST_STOP_ON_DROP: assert property (start_off_long |-> !motion_enable_q && !move_start_q)
		else $error("motion still enabled after start dropped");
	AST_START_ENABLED: assert property (move_start_q |-> motion_enable_q)
		else $error("move started while motion disabled");
	AST_START_PULSE: assert property (move_start_q |=> !move_start_q)
		else $error("move start longer than one cycle");
	AST_ABORT_PULSE: assert property (move_abort_q |=> !move_abort_q)
		else $error("abort longer than one cycle");
	AST_TARGET_HOLD: assert property ($changed(move_target_q) || $changed(move_absolute_q) |-> move_start_q)
		else $error("move target changed without a start");
	AST_WR_ANSWER: assert property (wr_both_taken |-> ##2 s_axi_bvalid)
		else $error("no write response one cycle after take");
	AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while response pending");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("no read data one cycle after take");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
endmodule // step_seq_checks
bind step_sequencer_top step_seq_checks i_chk (.core_clk(core_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.start_pin(start_pin), .move_start_q(move_start_q), .move_abort_q(move_abort_q),
	.move_absolute_q(move_absolute_q), .move_target_q(move_target_q),
	.motion_enable_q(motion_enable_q));
`default_nettype wire

// ### test/step_sequencer_top_tb.sv
// Self-checking bench for the data-set step sequencer
`timescale 1ns/1ps
`default_nettype none
`include "step_seq_map.vh"
module step_sequencer_top_tb;
	logic core_clk = 0;
	logic rst = 1;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, inpos = 0, st = 0, sp = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, mt;
	logic awr, wr, bv, arr, rv, ms, ma, mabs, me, spin, stpin;
	logic [1:0] br, rr;
	logic [4:0] mset;
	int error_cnt = 0, cmp_count = 0;
	always #5 core_clk = ~core_clk;
	step_ctrl_model i_ctrl (.core_clk(core_clk), .start_cmd(st), .step_cmd(sp),
		.start_pin(stpin), .step_pin(spin));
	step_sequencer_top #(.MS_CYCLES(10)) i_dut (.core_clk(core_clk), .rst(rst),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.start_pin(stpin), .step_pin(spin), .move_in_position(inpos),
		.move_start_q(ms), .move_abort_q(ma), .move_absolute_q(mabs),
		.move_target_q(mt), .move_set_q(mset), .motion_enable_q(me));
	////////////////////////////////////////////////////////////////
	task ck(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t ns: got %0h, expected %0h", $time, g, e);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		awv <= 1;
		wv <= 1;
		awa <= a;
		wd <= d;
		bre <= 1;
		do begin
			@(posedge core_clk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
		end while (!bv);
		bre <= 0;
		ck(32'(br), e);
		@(posedge core_clk);
	endtask
	task rreg(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		arv <= 1;
		ara <= a;
		rre <= 1;
		do begin
			@(posedge core_clk);
			if (arr) arv <= 0;
		end while (!rv);
		rre <= 0;
		ck(rd, d);
		ck(32'(rr), e);
		@(posedge core_clk);
	endtask
	// Bounded wait for the next move start; c equals lim when none came
	task wait_mv(input int lim, output int c);
		for (c = 0; c < lim; c++) begin
			@(posedge core_clk);
			if (ms) break;
		end
	endtask
	task stepck(input int lim, input logic e);
		int c;
		wait_mv(lim, c);
		ck(32'(c < lim), 32'(e));
		if (e) begin
			ck(32'(mset), 1);
			ck(32'(mabs), 0);
			ck(mt, 32'h0000_0200);
		end
	endtask
	task go(input logic [15:0] cfg, v1, v2, input logic pi);
		int c;
		sp <= pi;
		wreg(`OFS_STEP_CONFIG, 32'(cfg), 0);
		wreg(`OFS_VALUE_ONE, 32'(v1), 0);
		wreg(`OFS_VALUE_TWO, 32'(v2), 0);
		st <= 1;
		wait_mv(30, c);
		ck(32'(c < 30), 1);
		ck(32'(me), 1);
		ck(32'(mset), 0);
		ck(32'(mabs), 1);
		ck(mt, 32'h0000_0100);
	endtask
	task stop;
		st <= 0;
		inpos <= 0;
		repeat (8) @(posedge core_clk);
		ck(32'(me), 0);
		stepck(10, 0);
	endtask
	// Step must wait for its condition, then follow the pin toggles
	task cc(input logic [15:0] cfg, v1, v2, input logic pi, f, s);
		go(cfg, v1, v2, pi);
		inpos <= 1;
		stepck(15, 0);
		sp <= ~sp;
		stepck(20, f);
		if (!f) begin
			sp <= ~sp;
			stepck(20, s);
		end
		stop;
	endtask
	task t_abort;
		int c;
		logic ab;
		ab = 0;
		go(16'h0000, 0, 0, 0);
		for (c = 0; c < 15; c++) begin
			@(posedge core_clk);
			if (ma) ab = 1;
			if (ms) break;
		end
		ck(32'(ab), 1);
		ck(32'(mset), 1);
		stop;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int c;
		repeat (12) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		rreg(`OFS_VALUE_ONE, 0, 0);
		rreg(`OFS_VALUE_TWO, 0, 0);
		wreg(`OFS_VALUE_TWO, 32'h0000_FFFF, 0);
		rreg(`OFS_VALUE_TWO, 32'h0000_FFFF, 0);
		rreg(8'h40, 0, 2);
		wreg(`OFS_STATUS, 1, 2);
		st <= 1;
		repeat (10) @(posedge core_clk);
		ck(32'(me), 0);
		st <= 0;
		wreg(`OFS_CONTROL_MODE, 32'h0000_00C0, 0);
		wreg(`OFS_STARTUP_MANNER, 1, 0);
		st <= 1;
		repeat (10) @(posedge core_clk);
		ck(32'(me), 0);
		st <= 0;
		wreg(`OFS_STARTUP_MANNER, 0, 0);
		wreg(`OFS_TABLE_INDEX, 0, 0);
		wreg(`OFS_TABLE_POS, 32'h0000_0100, 0);
		wreg(`OFS_TABLE_COMMIT, 1, 0);
		wreg(`OFS_TABLE_INDEX, 1, 0);
		wreg(`OFS_TABLE_POS, 32'h0000_0200, 0);
		wreg(`OFS_TABLE_COMMIT, 2, 0);
		wreg(`OFS_SEQ_SETUP, 32'h0000_0100, 0);
		go(16'h1130, 0, 3, 0);
		stepck(15, 0);
		inpos <= 1;
		stepck(8, 1);
		stop;
		go(16'h1001, 5, 0, 0);
		repeat (5) @(posedge core_clk);
		inpos <= 1;
		wait_mv(80, c);
		ck(32'(c >= 40 && c <= 58), 1);
		stop;
		cc(16'h1002, 0, 0, 1, 0, 1);
		cc(16'h1002, 1, 0, 0, 0, 1);
		cc(16'h1002, 2, 0, 0, 1, 1);
		cc(16'h1002, 5, 0, 0, 0, 0);
		cc(16'h1003, 3, 0, 0, 1, 1);
		cc(16'h1003, 4, 0, 1, 1, 1);
		cc(16'h1003, 0, 0, 0, 0, 0);
		cc(16'h1123, 3, 0, 1, 0, 1);
		cc(16'h1223, 4, 0, 1, 1, 1);
		cc(16'h1023, 4, 0, 1, 1, 1);
		cc(16'h1231, 1000, 3, 0, 1, 1);
		t_abort;
		complete_run;
	end
	initial begin
		#200_000;
		error_cnt++;
		complete_run;
	end
endmodule // step_sequencer_top_tb
`default_nettype wire
